// ---- rtl/rbc_pkg.sv ----
// Purpose: Shared constants for the registered byte comparator
// Assumes: Eight-bit slice, one clock
// Notes: Mode codes are {op_select_1, op_select_0}
package rbc_pkg;
   // ----------------------------------------
   // Widths and codes
   // ----------------------------------------
   localparam int RBC_WIDTH = 8;
   localparam logic [1:0] RBC_SEL_HOLD = 2'h0;
   localparam logic [1:0] RBC_SEL_READ = 2'h2;
   localparam logic [1:0] RBC_SEL_SHIFT = 2'h1;
   localparam logic [1:0] RBC_SEL_LOAD = 2'h3;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RBC_STORE_RESET = 8'h00;
   localparam logic RBC_FLAG_OFF = 1'b1;
endpackage

// ---- rtl/rbc_sync2.sv ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Asynchronous active-low reset
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module rbc_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_reg <= '0;
         o_q <= '0;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule // rbc_sync2
`default_nettype wire

// ---- rtl/rbc_comparator.sv ----
// Purpose: Registered byte comparator slice with shift, load, read, hold
// Assumes: Pins are asynchronous and pass two flip-flops before use
// Notes: Flags are open-drain style, data bus is three-state, enables active low
//
// Functional notes
// - Eight-bit register, parallel or serial load
// - Updates only on rising clock edge
// - Both selects low: hold contents
// - Read mode drives bus from a clocked output register, contents held
// - Shift toward MSB from chain input
// - Load mode captures bus byte
// - Continuously compare register with bus byte
// - Status gate high releases all flags
// - Format select: unsigned or twos complement
// - Low chain input kills greater/less flags
// - Chain out high only if in high and equal, except shift mode passes out the MSB
// - Active-off flags per comparison result
`timescale 1ns/1ps
`default_nettype none
module rbc_comparator #(
   parameter int WIDTH = rbc_pkg::RBC_WIDTH
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_op_select_0,
   input wire logic i_op_select_1,
   input wire logic i_chain_in,
   input wire logic i_status_gate_n,
   input wire logic i_signed_mode,
   input wire logic [WIDTH-1:0] i_data_bus,
   output logic [WIDTH-1:0] o_data_bus,
   output logic [WIDTH-1:0] o_data_bus_oen,
   output logic o_chain_out,
   output logic o_match_flag,
   output logic o_match_flag_oen,
   output logic o_above_flag,
   output logic o_above_flag_oen,
   output logic o_below_flag,
   output logic o_below_flag_oen
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_reg;
   logic rstn_reg;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_reg <= 1'b0;
         rstn_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rstn_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int SW = WIDTH + 5;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_sync;
   assign pin_raw = {i_data_bus, i_signed_mode, i_status_gate_n, i_chain_in,
                     i_op_select_1, i_op_select_0};
   rbc_sync2 #(.W(SW)) u_sync (
      .i_clk(i_clk),
      .i_rstn(rstn_reg),
      .i_d(pin_raw),
      .o_q(pin_sync)
   );
   wire [1:0] sel = pin_sync[1:0];
   wire chain_in = pin_sync[2];
   wire gate_n = pin_sync[3];
   wire signed_mode = pin_sync[4];
   wire [WIDTH-1:0] bus_in = pin_sync[SW-1:5];

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   // Assumed select codes
   wire mode_read = (sel == rbc_pkg::RBC_SEL_READ);
   wire mode_shift = (sel == rbc_pkg::RBC_SEL_SHIFT);
   wire mode_load = (sel == rbc_pkg::RBC_SEL_LOAD);

   // ----------------------------------------
   // Storage register
   // ----------------------------------------
   // No reset on the part; a defined start value eases test
   logic [WIDTH-1:0] store_reg;
   logic [WIDTH-1:0] store_next;
   assign store_next = mode_load ? bus_in :
                       mode_shift ? {store_reg[WIDTH-2:0], chain_in} :
                       store_reg;
   always_ff @(posedge i_clk or negedge rstn_reg) begin
      if (!rstn_reg) begin
         store_reg <= rbc_pkg::RBC_STORE_RESET;
      end else begin
         store_reg <= store_next;
      end
   end

   // ----------------------------------------
   // Comparator
   // ----------------------------------------
   function automatic logic is_above(input logic [WIDTH-1:0] a,
                                     input logic [WIDTH-1:0] b,
                                     input logic sgn);
      logic [WIDTH-1:0] fa;
      logic [WIDTH-1:0] fb;
      fa = a;
      fb = b;
      // Flipping the sign bits turns signed order into unsigned order
      if (sgn) begin
         fa[WIDTH-1] = ~a[WIDTH-1];
         fb[WIDTH-1] = ~b[WIDTH-1];
      end
      return fa > fb;
   endfunction

   // While reading, the bus carries our own byte, so it compares equal
   wire [WIDTH-1:0] cmp_bus = mode_read ? store_reg : bus_in;
   wire is_eq = (store_reg == cmp_bus);
   wire is_gt = is_above(store_reg, cmp_bus, signed_mode);
   wire is_lt = is_above(cmp_bus, store_reg, signed_mode);

   // ----------------------------------------
   // Flag and chain outputs
   // ----------------------------------------
   // Flag value: 1 released (off/high), 0 pulled low
   logic eq_rel;
   logic gt_rel;
   logic lt_rel;
   logic chain_next;
   always_comb begin
      eq_rel = 1'b1;
      gt_rel = 1'b1;
      lt_rel = 1'b1;
      if (!gate_n) begin
         eq_rel = is_eq;
         gt_rel = chain_in ? is_gt : 1'b1;
         lt_rel = chain_in ? is_lt : 1'b1;
         if (chain_in && is_eq) begin
            gt_rel = 1'b0;
            lt_rel = 1'b0;
         end
      end
   end
   assign chain_next = mode_shift ? store_reg[WIDTH-1] : (chain_in & is_eq);

   always_ff @(posedge i_clk or negedge rstn_reg) begin
      if (!rstn_reg) begin
         o_match_flag_oen <= 1'b1;
         o_above_flag_oen <= 1'b1;
         o_below_flag_oen <= 1'b1;
         o_chain_out <= 1'b0;
         o_data_bus_oen <= '1;
         o_data_bus <= '0;
      end else begin
         o_match_flag_oen <= eq_rel;
         o_above_flag_oen <= gt_rel;
         o_below_flag_oen <= lt_rel;
         o_chain_out <= chain_next;
         o_data_bus_oen <= {WIDTH{~mode_read}};
         o_data_bus <= store_next;
      end
   end

   // Open-drain flags only ever pull low
   always_ff @(posedge i_clk or negedge rstn_reg) begin
      if (!rstn_reg) begin
         o_match_flag <= 1'b0;
         o_above_flag <= 1'b0;
         o_below_flag <= 1'b0;
      end else begin
         o_match_flag <= 1'b0;
         o_above_flag <= 1'b0;
         o_below_flag <= 1'b0;
      end
   end
endmodule // rbc_comparator
`default_nettype wire

// ---- bench/rbc_properties.sv ----
// Purpose: Port checks for the comparator slice
// Assumes: Outputs follow pins three edges later
// Notes: up_reg masks the reset ramp
`timescale 1ns/1ps
`default_nettype none
module rbc_properties (
   input wire logic i_clk, i_rstn, i_op_select_0, i_op_select_1,
   input wire logic i_chain_in, i_status_gate_n, i_signed_mode,
   input wire logic [7:0] i_data_bus, o_data_bus, o_data_bus_oen,
   input wire logic o_chain_out, o_match_flag, o_match_flag_oen, o_above_flag,
   input wire logic o_above_flag_oen, o_below_flag, o_below_flag_oen
);
   logic [3:0] up_reg;
   wire ok = up_reg > 4'h8;
   wire [1:0] sel = {i_op_select_1, i_op_select_0};
   wire rd = sel == rbc_pkg::RBC_SEL_READ;
   wire sh = sel == rbc_pkg::RBC_SEL_SHIFT;
   wire en = !i_status_gate_n && i_chain_in;
   wire qt = en && (rd || sel == rbc_pkg::RBC_SEL_HOLD);
   wire [2:0] fo = {o_match_flag_oen, o_above_flag_oen, o_below_flag_oen};
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         up_reg <= 4'h0;
      else if (!ok)
         up_reg <= up_reg + 4'h1;
   // ----
   // Checks
   // ----
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn || !ok);
   chk_read_drive: assert property ($past(rd, 3) |-> o_data_bus_oen == 8'h00)
      else $error("bus not driven in read");
   chk_bus_release: assert property (!$past(rd, 3) |-> o_data_bus_oen == 8'hff)
      else $error("bus driven outside read");
   chk_read_frozen: assert property ($past(rd, 3) && $past(rd, 4) |-> $stable(o_data_bus))
      else $error("register moved in read");
   chk_gate_off: assert property ($past(i_status_gate_n, 3) |-> fo == 3'h7)
      else $error("flag active with gate off");
   chk_chain_kill: assert property (!$past(i_chain_in, 3) |-> fo[1:0] == 2'h3)
      else $error("order flag with chain low");
   chk_one_flag: assert property ($past(en, 3) && $past(en, 4) |-> $onehot(fo))
      else $error("not one released flag");
   chk_chain_low: assert property (!$past(i_chain_in, 3) && !$past(sh, 3) |-> !o_chain_out)
      else $error("chain out high with chain in low");
   chk_chain_match: assert property ($past(qt, 3) && $past(qt, 4) && $past(qt, 5)
      |-> o_chain_out == o_match_flag_oen)
      else $error("chain out differs from match");
   cover property ($past(rd, 3));
   cover property ($past(sh, 3) && o_chain_out);
   cover property (o_match_flag_oen && !i_status_gate_n);
endmodule // rbc_properties
bind rbc_comparator rbc_properties u_chk (.*);
`default_nettype wire

// ---- bench/rbc_far_model.sv ----
// Purpose: Bus master and wired-AND flag lines
// Assumes: Single slice, other slices released
// Notes: Flag lines have pull-ups
`timescale 1ns/1ps
`default_nettype none
module rbc_far_model (
   input wire logic [7:0] i_master,
   input wire logic [7:0] i_dev,
   input wire logic [7:0] i_dev_oen,
   input wire logic [2:0] i_val,
   input wire logic [2:0] i_oen,
   output logic [7:0] o_bus,
   output logic [2:0] o_lv
);
   assign o_bus = (i_dev & ~i_dev_oen) | (i_master & i_dev_oen);
   assign o_lv = i_oen | i_val;
endmodule // rbc_far_model
`default_nettype wire

// ---- bench/tb_registered_byte_comparator.sv ----
// Purpose: Random and corner trials of one slice
// Assumes: Slice is top of a cascade, chain in high except while it feeds shift data
// Notes: Bus master holds the bus outside read
`timescale 1ns/1ps
`default_nettype none
module tb_registered_byte_comparator;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_op_select_0 = 1'b0, i_op_select_1 = 1'b0;
   logic i_chain_in = 1'b1, i_status_gate_n = 1'b0, i_signed_mode = 1'b0;
   logic [7:0] m = 8'h00, st = 8'h00;
   wire [7:0] i_data_bus, o_data_bus, o_data_bus_oen;
   wire [2:0] lv;
   wire o_chain_out, o_match_flag, o_match_flag_oen, o_above_flag;
   wire o_above_flag_oen, o_below_flag, o_below_flag_oen;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   integer seed = 32'hb5d5_b78c;
   always #4 i_clk = ~i_clk;
   rbc_comparator DUT (.*);
   rbc_far_model u_far (.i_master(m), .i_dev(o_data_bus), .i_dev_oen(o_data_bus_oen),
      .i_val({o_match_flag, o_above_flag, o_below_flag}),
      .i_oen({o_match_flag_oen, o_above_flag_oen, o_below_flag_oen}), .o_bus(i_data_bus),
      .o_lv(lv));
   task automatic print_verdict;
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Mode held exactly n edges; called on a falling edge
   task automatic go(input logic [1:0] s, input int n);
      {i_op_select_1, i_op_select_0} = s;
      repeat (n) @(negedge i_clk);
   endtask
   // Expected line levels {match, above, below}
   function automatic logic [7:0] want(input logic [7:0] r, x, input logic s, g);
      logic gt;
      gt = s ? ($signed(r) > $signed(x)) : (r > x);
      return g ? 8'h07 : {5'h0, r == x, gt, r != x && !gt};
   endfunction
   task automatic trial(input logic [7:0] x, y, input logic s, g, c);
      m = x;
      go(rbc_pkg::RBC_SEL_LOAD, 3);
      st = x;
      m = y;
      i_signed_mode = s;
      i_status_gate_n = g;
      go(rbc_pkg::RBC_SEL_HOLD, 6);
      chk({5'h0, lv}, want(st, y, s, g));
      chk({7'h0, o_chain_out}, {7'h0, st == y});
      i_chain_in = c;
      go(rbc_pkg::RBC_SEL_SHIFT, 3);
      st = {st[4:0], c, c, c};
      i_chain_in = 1'b1;
      go(rbc_pkg::RBC_SEL_HOLD, 4);
      go(rbc_pkg::RBC_SEL_READ, 6);
      chk(o_data_bus, st);
      chk(o_data_bus_oen, 8'h00);
      go(rbc_pkg::RBC_SEL_HOLD, 4);
   endtask
   // Timeout well past the expected 601 cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      repeat (3) @(negedge i_clk);
      i_rstn = 1'b1;
      // lone slice: chain out feeds nothing
      // lone slice is top, so signed mode may be set
      trial(8'h80, 8'h7f, 1'b0, 1'b0, 1'b1);
      trial(8'h80, 8'h7f, 1'b1, 1'b0, 1'b0);
      trial(8'h3c, 8'h3c, 1'b0, 1'b1, 1'b1);
      repeat (20) trial($random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed));
      print_verdict;
   end
endmodule // tb_registered_byte_comparator
`default_nettype wire
